//--- common/ssp_pkg.sv
// Package of constants and carriers for the synchronous serial shift port
package ssp_pkg;

	// ==========================================================
	// Word sizes and shift-clock edge counts
	localparam int         W_DATA     = 16;
	localparam int         TX_DEPTH   = 2;
	localparam logic [5:0] EDGES_8    = 6'h10;
	localparam logic [5:0] EDGES_16   = 6'h20;
	localparam logic [5:0] CNT_RESET  = 6'h00;
	localparam logic [15:0] WORD_RESET = 16'h0000;

	// ==========================================================
	// Prescaler decode: primary field code to divisor
	localparam logic [1:0] PRIMARY_DIV_FIELD_DIV1  = 2'h3;
	localparam logic [1:0] PRIMARY_DIV_FIELD_DIV4  = 2'h2;
	localparam logic [1:0] PRIMARY_DIV_FIELD_DIV16 = 2'h1;
	localparam logic [9:0] PRIM_1     = 10'h001;
	localparam logic [9:0] PRIM_4     = 10'h004;
	localparam logic [9:0] PRIM_16    = 10'h010;
	localparam logic [9:0] PRIM_64    = 10'h040;
	localparam logic [9:0] SEC_BASE   = 10'h008;
	localparam logic [9:0] DIV_RESET  = 10'h000;

	// ==========================================================
	// Register layouts (bit 15 first)
	typedef struct packed {
		logic [2:0] rsv;
		logic       dis_sck;
		logic       dis_sdo;
		logic       word_size_bit;
		logic       sample_phase_bit;
		logic       clock_edge_bit;
		logic       select_pin_enable;
		logic       clock_polarity_bit;
		logic       master_select_bit;
		logic [2:0] secondary_div_field;
		logic [1:0] primary_div_field;
	} ctrl_t;

	typedef struct packed {
		logic       port_enable_bit;
		logic [7:0] rsv_hi;
		logic       rx_overflow_flag;
		logic [3:0] rsv_lo;
		logic       tx_full;
		logic       rx_full;
	} stat_t;

	localparam stat_t STAT_RESET = 16'h0000;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RUN  = 2'b01
	} state_t;

endpackage : ssp_pkg

//--- src/ssp_prescaler.sv
// Two-stage prescaler that turns the system clock into shift-clock edge ticks
`timescale 1ns/1ns
module ssp_prescaler
	import ssp_pkg::*;
(
	input  wire logic       i_clk,
	input  wire logic       i_rst_b,
	input  wire logic       i_run,
	input  wire logic [1:0] i_primary_div_field,
	input  wire logic [2:0] i_secondary_div_field,
	output logic            o_tick
);

	logic [9:0] prim;
	logic [9:0] sec;
	logic [9:0] lim;
	logic [9:0] cnt_q;
	logic [9:0] cnt_d;
	logic       tick_d;

	// ==========================================================
	// Divisor decode
	always_comb begin
		case (i_primary_div_field)
			PRIMARY_DIV_FIELD_DIV1:  prim = PRIM_1;
			PRIMARY_DIV_FIELD_DIV4:  prim = PRIM_4;
			PRIMARY_DIV_FIELD_DIV16: prim = PRIM_16;
			default:    prim = PRIM_64;
		endcase
		sec = SEC_BASE - {7'h00, i_secondary_div_field};
		lim = prim * sec - PRIM_1;
	end

	// ==========================================================
	// Counter; restarts whenever the master is not shifting
	always_comb begin
		cnt_d  = DIV_RESET;
		tick_d = 1'b0;
		if (i_run && cnt_q != lim) begin
			cnt_d = cnt_q + PRIM_1;
		end else if (i_run) begin
			tick_d = 1'b1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			cnt_q  <= DIV_RESET;
			o_tick <= 1'b0;
		end else begin
			cnt_q  <= cnt_d;
			o_tick <= tick_d;
		end
	end

	tick_rate_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		o_tick |-> $past(i_run) && $past(cnt_q) == $past(lim))
		else $error("prescaler tick off its terminal count");

endmodule : ssp_prescaler

//--- src/ssp_fifo2.sv
// Small valid/ready buffer holding transmit words ahead of the shift register
`timescale 1ns/1ns
module ssp_fifo2
	import ssp_pkg::*;
#(
	parameter int WIDTH = W_DATA,
	parameter int DEPTH = TX_DEPTH
) (
	input  wire logic             i_clk,
	input  wire logic             i_rst_b,
	input  wire logic             i_wr_valid,
	input  wire logic [WIDTH-1:0] i_wr_data,
	output logic                  o_wr_ready,
	output logic                  o_rd_valid,
	output logic [WIDTH-1:0]      o_rd_data,
	input  wire logic             i_rd_ready
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [WIDTH-1:0] mem_d [DEPTH];
	logic [AW-1:0]    wptr_q, wptr_d;
	logic [AW-1:0]    rptr_q, rptr_d;
	logic [AW:0]      cnt_q, cnt_d;
	logic             push;
	logic             pop;

	assign push      = i_wr_valid && o_wr_ready;
	assign pop       = i_rd_ready && o_rd_valid;
	assign o_rd_data = mem_q[rptr_q];

	// ==========================================================
	// Storage, one entry per loop pass
	for (genvar g = 0; g < DEPTH; g++) begin : g_ent
		always_comb begin
			mem_d[g] = mem_q[g];
			if (push && wptr_q == AW'(g)) begin
				mem_d[g] = i_wr_data;
			end
		end
		always_ff @(posedge i_clk) begin
			mem_q[g] <= mem_d[g];
		end
	end

	// ==========================================================
	// Pointers and fill level; flags are registered from the next level
	always_comb begin
		wptr_d = push ? wptr_q + AW'(1) : wptr_q;
		rptr_d = pop ? rptr_q + AW'(1) : rptr_q;
		cnt_d  = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			wptr_q     <= '0;
			rptr_q     <= '0;
			cnt_q      <= '0;
			o_wr_ready <= 1'b1;
			o_rd_valid <= 1'b0;
		end else begin
			wptr_q     <= wptr_d;
			rptr_q     <= rptr_d;
			cnt_q      <= cnt_d;
			o_wr_ready <= cnt_d != (AW+1)'(DEPTH);
			o_rd_valid <= cnt_d != '0;
		end
	end

endmodule : ssp_fifo2

//--- src/ssp_core.sv
// Synchronous serial shift port: shift engine, buffers, status and interrupt flags
//
// Notes on behaviour
// - Each transfer shifts 8 or 16 bits out and 8 or 16 bits in together.
// - Shift clock pin is driven as master and taken as input as slave.
// - A finished transfer sets the transfer-done flag and asks for an interrupt.
// - The transfer-done interrupt is masked while its enable is low.
// - A completed received word is copied from the shift register to the receive buffer.
// - Full receive buffer at completion sets overflow; the new word is dropped.
// - While overflow is set, all shift clock edges are ignored.
// - At completion the received word is kept, then pending transmit data loads.
// - One buffer address: reads give receive data, writes load transmit data.
// - As master, a transfer starts as soon as transmit data is written.
// - The enable bit turns the port on; configure and clear overflow first.
// - Master-select high makes the port master, low makes it slave.
// - Select pin is active low; port uses four serial pins.
// - A separate interrupt reports error conditions.
// - Master shift clock is system rate over 2 times primary 1/4/16/64 times secondary 1..8.
// - Word-size bit set gives 16-bit transfers, clear gives 8-bit.
// - Clock-polarity bit set makes the idle level high, clear makes it low.
// - Clock-edge bit set changes data on active-to-idle, else idle-to-active.
// - Master sample-phase bit set samples at bit end, else at bit middle.
`timescale 1ns/1ns
module ssp_core
	import ssp_pkg::*;
(
	input  wire logic        i_clk,
	input  wire logic        i_rst_b,
	input  wire logic        i_port_enable_bit,
	input  wire ctrl_t       i_port_control_one,
	input  wire logic        i_ovf_clear,
	input  wire logic        i_xfer_done_irq_enable,
	input  wire logic        i_irq_clear,
	input  wire logic        i_buf_wr_valid,
	input  wire logic [15:0] i_buf_wr_data,
	output logic             o_buf_wr_ready,
	input  wire logic        i_buf_rd,
	output logic [15:0]      o_buf_rd_data,
	output stat_t            o_port_status_reg,
	output logic             o_xfer_done_irq_flag,
	output logic             o_xfer_done_irq,
	output logic             o_error_irq,
	input  wire logic        i_serial_in_pin,
	input  wire logic        i_shift_clock_pin,
	output logic             o_shift_clock_pin,
	output logic             o_shift_clock_oe_b,
	output logic             o_serial_out_pin,
	output logic             o_serial_out_oe_b,
	input  wire logic        i_select_low_pin_b
);

	// ==========================================================
	// Declarations
	ctrl_t       cfg;
	state_t      state_q, state_d;
	logic [15:0] sr_q, sr_d;
	logic [15:0] rx_q, rx_d;
	logic [15:0] shifted;
	logic [15:0] word;
	logic [15:0] tx_word;
	logic [5:0]  cnt_q, cnt_d;
	logic [5:0]  last;
	logic        bit_q, bit_d;
	logic        sck_q, sck_d;
	logic        sck_in_q;
	logic        rbf_q, rbf_d;
	logic        ovf_q, ovf_d;
	logic        flag_d;
	logic        en, master, sel_ok, smp_eff;
	logic        tick, run;
	logic        slave_edge, master_edge, edge_ev;
	logic        new_lvl, lead, final_e;
	logic        samp, shft, lsb;
	logic        tx_valid, tx_pop;
	logic        done_ev;

	assign cfg = i_port_control_one;

	// ==========================================================
	// Transmit holding buffer; a full buffer stalls the writer
	ssp_fifo2 #(
		.WIDTH (W_DATA),
		.DEPTH (TX_DEPTH)
	) u_tx_holding_buf (
		.i_clk      (i_clk),
		.i_rst_b    (i_rst_b),
		.i_wr_valid (i_buf_wr_valid),
		.i_wr_data  (i_buf_wr_data),
		.o_wr_ready (o_buf_wr_ready),
		.o_rd_valid (tx_valid),
		.o_rd_data  (tx_word),
		.i_rd_ready (tx_pop)
	);

	// ==========================================================
	// Shift clock pacing for master mode
	assign run = en && master && state_q == ST_RUN && !ovf_q;

	ssp_prescaler u_prescaler (
		.i_clk                 (i_clk),
		.i_rst_b               (i_rst_b),
		.i_run                 (run),
		.i_primary_div_field   (cfg.primary_div_field),
		.i_secondary_div_field (cfg.secondary_div_field),
		.o_tick                (tick)
	);

	// ==========================================================
	// Edge classification
	// Every edge is leading (idle to active) or trailing. The data
	// changes on trailing edges when the clock-edge bit is set, else on
	// leading ones; the first leading change is skipped because the
	// first bit is already on the pin from the load.
	always_comb begin
		en          = i_port_enable_bit;
		master      = cfg.master_select_bit;
		sel_ok      = master || !cfg.select_pin_enable || !i_select_low_pin_b;
		smp_eff     = master && cfg.sample_phase_bit;
		last        = cfg.word_size_bit ? EDGES_16 : EDGES_8;
		slave_edge  = !master && sel_ok && (i_shift_clock_pin != sck_in_q);
		master_edge = master && tick && state_q == ST_RUN;
		edge_ev     = en && !ovf_q && (slave_edge || master_edge);
		new_lvl     = master ? !sck_q : i_shift_clock_pin;
		lead        = new_lvl != cfg.clock_polarity_bit;
		final_e     = (cnt_q + 6'h01) == last;
		if (cfg.clock_edge_bit) begin
			samp = smp_eff ? !lead : lead;
			shft = !lead;
		end else begin
			samp = final_e || (smp_eff ? (lead && cnt_q != CNT_RESET) : !lead);
			shft = final_e || (lead && cnt_q != CNT_RESET);
		end
		lsb     = samp ? i_serial_in_pin : bit_q;
		shifted = {sr_q[14:0], lsb};
		word    = cfg.word_size_bit ? shifted : {8'h00, shifted[7:0]};
		done_ev = edge_ev && final_e;
	end

	// ==========================================================
	// Shift engine, buffers and flags
	always_comb begin
		state_d = state_q;
		sr_d    = sr_q;
		rx_d    = rx_q;
		cnt_d   = cnt_q;
		bit_d   = bit_q;
		sck_d   = sck_q;
		tx_pop  = 1'b0;
		// Hardware sets below override these clears in the same cycle
		rbf_d   = rbf_q && !i_buf_rd;
		ovf_d   = ovf_q && !i_ovf_clear;
		flag_d  = o_xfer_done_irq_flag && !i_irq_clear;
		if (!en) begin
			state_d = ST_IDLE;
			cnt_d   = CNT_RESET;
			sck_d   = cfg.clock_polarity_bit;
		end else if (edge_ev) begin
			state_d = ST_RUN;
			cnt_d   = cnt_q + 6'h01;
			if (master) begin
				sck_d = !sck_q;
			end
			if (samp) begin
				bit_d = i_serial_in_pin;
			end
			if (shft) begin
				sr_d = shifted;
			end
			if (final_e) begin
				state_d = ST_IDLE;
				cnt_d   = CNT_RESET;
				flag_d  = 1'b1;
				if (rbf_q) begin
					ovf_d = 1'b1;
				end else begin
					rx_d  = word;
					rbf_d = 1'b1;
				end
				if (tx_valid) begin
					tx_pop  = 1'b1;
					sr_d    = tx_word;
					state_d = ST_RUN;
				end
			end
		end else if (!sel_ok) begin
			// Deselect in the middle of a word drops the partial word
			cnt_d = CNT_RESET;
		end else if (state_q == ST_IDLE && tx_valid && !ovf_q) begin
			tx_pop  = 1'b1;
			sr_d    = tx_word;
			state_d = ST_RUN;
			sck_d   = cfg.clock_polarity_bit;
		end else if (state_q == ST_IDLE) begin
			sck_d = cfg.clock_polarity_bit;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			state_q              <= ST_IDLE;
			sr_q                 <= WORD_RESET;
			rx_q                 <= WORD_RESET;
			cnt_q                <= CNT_RESET;
			bit_q                <= 1'b0;
			sck_q                <= 1'b0;
			sck_in_q             <= 1'b0;
			rbf_q                <= 1'b0;
			ovf_q                <= 1'b0;
			o_xfer_done_irq_flag <= 1'b0;
		end else begin
			state_q              <= state_d;
			sr_q                 <= sr_d;
			rx_q                 <= rx_d;
			cnt_q                <= cnt_d;
			bit_q                <= bit_d;
			sck_q                <= sck_d;
			sck_in_q             <= i_shift_clock_pin;
			rbf_q                <= rbf_d;
			ovf_q                <= ovf_d;
			o_xfer_done_irq_flag <= flag_d;
		end
	end

	// ==========================================================
	// Pin and status outputs, all registered
	// Outputs follow the next values so pins line up with the state; tx_full follows the current o_buf_wr_ready
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_shift_clock_pin  <= 1'b0;
			o_shift_clock_oe_b <= 1'b1;
			o_serial_out_pin   <= 1'b0;
			o_serial_out_oe_b  <= 1'b1;
			o_buf_rd_data      <= WORD_RESET;
			o_xfer_done_irq    <= 1'b0;
			o_error_irq        <= 1'b0;
			o_port_status_reg  <= STAT_RESET;
		end else begin
			o_shift_clock_pin  <= sck_d;
			o_shift_clock_oe_b <= !(en && master && !cfg.dis_sck);
			o_serial_out_pin   <= cfg.word_size_bit ? sr_d[15] : sr_d[7];
			o_serial_out_oe_b  <= !(en && sel_ok && !cfg.dis_sdo);
			o_buf_rd_data      <= rx_d;
			o_xfer_done_irq    <= flag_d && i_xfer_done_irq_enable;
			o_error_irq        <= ovf_d;
			o_port_status_reg  <= '{
				port_enable_bit:  en,
				rsv_hi:           8'h00,
				rx_overflow_flag: ovf_d,
				rsv_lo:           4'h0,
				tx_full:          !o_buf_wr_ready,
				rx_full:          rbf_d
			};
		end
	end

	// ==========================================================
	// Checks
	word_len_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		done_ev |-> cnt_q == last - 6'h01)
		else $error("transfer ended on wrong edge count");

	done_flag_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		done_ev |=> o_xfer_done_irq_flag)
		else $error("done flag not raised after a transfer");

	irq_mask_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		!i_xfer_done_irq_enable |=> !o_xfer_done_irq)
		else $error("done interrupt leaked while masked");

	rx_copy_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		done_ev && !rbf_q |=> o_buf_rd_data == $past(word) && o_port_status_reg.rx_full)
		else $error("received word not copied to the buffer");

	ovf_drop_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		done_ev && rbf_q |=> ovf_q && $stable(rx_q) && o_error_irq)
		else $error("overflow not flagged or word not dropped");

	ovf_freeze_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		ovf_q && en |=> $stable(cnt_q) && $stable(sr_q[15:1]))
		else $error("shifting went on during overflow");

	master_start_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		en && master && state_q == ST_IDLE && tx_valid && !ovf_q && !edge_ev
		|=> state_q == ST_RUN)
		else $error("master did not start on pending data");

	sck_dir_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		!master |=> o_shift_clock_oe_b)
		else $error("slave drove the shift clock");

	// ==========================================================
	// Pin levels and status tracking
	// A master between words must rest at the idle level, or the far
	// side would count a spurious edge at the next word.
	master_drive_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		en && master && !cfg.dis_sck |=> !o_shift_clock_oe_b)
		else $error("master left the shift clock undriven");

	sck_idle_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		en && master && state_q == ST_IDLE && !edge_ev
		|=> o_shift_clock_pin == $past(cfg.clock_polarity_bit))
		else $error("shift clock not at idle level");

	ovf_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		ovf_q && !i_ovf_clear |=> ovf_q)
		else $error("overflow dropped without a clear");

	tx_full_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		!o_buf_wr_ready |=> o_port_status_reg.tx_full)
		else $error("transmit full not reported");

	rx_clear_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		i_buf_rd && !done_ev |=> !o_port_status_reg.rx_full)
		else $error("buffer read did not clear receive full");

	sdo_release_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		!en |=> o_serial_out_oe_b)
		else $error("disabled port drove the data pin");

endmodule : ssp_core

//--- dv/ssp_far_peer.sv
// Far-side serial peripheral model that answers a master shift port
`timescale 1ns/1ns
module ssp_far_peer (
	input  wire logic        i_clk,
	input  wire logic        i_cpol,
	input  wire logic        i_w16,
	input  wire logic [15:0] i_reply,
	input  wire logic        i_sck,
	input  wire logic        i_mosi,
	output logic             o_miso,
	output logic [15:0]      o_got,
	output int               o_words,
	output int               o_edges,
	output int               o_period
);
	logic [15:0] sr_q;
	logic [15:0] rx_q;
	logic        sck_q;
	int          e_q;
	int          cyc_q;
	// Leading edge leaves the idle level: sample there, change data on the trailing edge
	wire lead  = (sck_q == i_cpol) && (i_sck != i_cpol);
	wire trail = (sck_q != i_cpol) && (i_sck == i_cpol);
	assign o_miso = i_w16 ? sr_q[15] : sr_q[7];
	initial begin
		sr_q = '0;
		rx_q = '0;
		sck_q = 1'b0;
		e_q = 0;
		cyc_q = 0;
		o_got = '0;
		o_words = 0;
		o_edges = 0;
		o_period = 0;
	end
	always @(posedge i_clk) begin
		sck_q <= i_sck;
		cyc_q <= cyc_q + 1;
		// Reply word stays loadable until the first edge of a word
		if (e_q == 0 && !lead) begin
			sr_q <= i_reply;
		end
		if (lead) begin
			rx_q <= {rx_q[14:0], i_mosi};
			o_period <= cyc_q;
			cyc_q <= 1;
		end
		if (lead || trail) begin
			o_edges <= o_edges + 1;
			e_q <= e_q + 1;
		end
		if (trail) begin
			sr_q <= sr_q << 1;
			if (e_q + 1 == (i_w16 ? 32 : 16)) begin
				e_q <= 0;
				o_got <= i_w16 ? rx_q : {8'h00, rx_q[7:0]};
				o_words <= o_words + 1;
			end
		end
	end
endmodule : ssp_far_peer

//--- dv/sync_serial_shift_port_tb.sv
// Self-checking testbench of the serial shift port in master mode, plus slave pin-direction checks
`timescale 1ns/1ns
module sync_serial_shift_port_tb;
	import ssp_pkg::*;
	logic        i_clk, i_rst_b, en, ovf_clr, irq_en, irq_clr, wr_v, rd, miso;
	logic        sck_in, sel_b, dflag, dirq, eirq, sck, sck_oe_b, sdo, sdo_oe_b;
	logic        wr_rdy, cpol, w16;
	logic [15:0] wr_d, rd_d, reply, got;
	ctrl_t       ctrl;
	stat_t       stat;
	int          words, edges, period, e0, err_total, checks_done, cycles;

	ssp_core dut_u (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_port_enable_bit(en),
		.i_port_control_one(ctrl), .i_ovf_clear(ovf_clr), .i_xfer_done_irq_enable(irq_en),
		.i_irq_clear(irq_clr), .i_buf_wr_valid(wr_v), .i_buf_wr_data(wr_d),
		.o_buf_wr_ready(wr_rdy), .i_buf_rd(rd), .o_buf_rd_data(rd_d),
		.o_port_status_reg(stat), .o_xfer_done_irq_flag(dflag), .o_xfer_done_irq(dirq),
		.o_error_irq(eirq), .i_serial_in_pin(miso), .i_shift_clock_pin(sck_in),
		.o_shift_clock_pin(sck), .o_shift_clock_oe_b(sck_oe_b), .o_serial_out_pin(sdo),
		.o_serial_out_oe_b(sdo_oe_b), .i_select_low_pin_b(sel_b));

	ssp_far_peer peer_u (.i_clk(i_clk), .i_cpol(cpol), .i_w16(w16), .i_reply(reply),
		.i_sck(sck), .i_mosi(sdo), .o_miso(miso), .o_got(got), .o_words(words),
		.o_edges(edges), .o_period(period));

	// ==========================================================
	// Clock, timeout and shared tasks
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end
	// Whole run needs about 1100 cycles; the ceiling leaves ample margin
	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 20000) begin
			err_total++;
			print_verdict;
		end
	end
	task tick(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask : tick
	task chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : chk
	task wr(input logic [15:0] d);
		wr_v = 1'b1;
		wr_d = d;
		while (wr_rdy !== 1'b1) tick(1);
		tick(1);
		wr_v = 1'b0;
	endtask : wr
	task wait_flag;
		int n;
		n = 0;
		while (dflag !== 1'b1 && n < 3000) begin
			tick(1);
			n++;
		end
		chk(n < 3000, 16'h0001, "done flag late");
		// The peer sees the last pin edge one cycle after the flag rises
		tick(1);
	endtask : wait_flag
	task pulse_rd;
		rd = 1'b1;
		tick(1);
		rd = 1'b0;
	endtask : pulse_rd
	task pulse_irq_clr;
		irq_clr = 1'b1;
		tick(1);
		irq_clr = 1'b0;
	endtask : pulse_irq_clr
	task setup(input logic m, input logic p, input logic b16);
		en = 1'b0;
		tick(1);
		ctrl = '0;
		ctrl.select_pin_enable = !m;
		ctrl.word_size_bit = b16;
		ctrl.clock_edge_bit = 1'b1;
		ctrl.clock_polarity_bit = p;
		ctrl.master_select_bit = m;
		ctrl.secondary_div_field = 3'h6;
		ctrl.primary_div_field = 2'h2;
		cpol = p;
		w16 = b16;
		ovf_clr = 1'b1;
		tick(1);
		ovf_clr = 1'b0;
		en = 1'b1;
		tick(1);
	endtask : setup

	// ==========================================================
	// Scenarios
	task t_reset;
		chk(stat, 16'h0000, "status after reset");
		chk(wr_rdy, 16'h0001, "ready after reset");
		chk({sck_oe_b, sdo_oe_b}, 16'h0003, "pins released");
		chk({dflag, dirq, eirq}, 16'h0000, "flags after reset");
	endtask : t_reset
	task t_word16;
		setup(1'b1, 1'b0, 1'b1);
		irq_en = 1'b1;
		chk(sck_oe_b, 16'h0000, "master drives clock");
		reply = 16'h3C5A;
		e0 = edges;
		wr(16'hA5C3);
		tick(14);
		chk(edges > e0, 16'h0001, "no prompt start");
		wait_flag;
		chk(got, 16'hA5C3, "word sent");
		chk(rd_d, 16'h3C5A, "word received");
		chk(stat.rx_full, 16'h0001, "rx full");
		chk(period, 16'h0010, "shift clock period");
		chk(edges - e0, 16'h0020, "edge count");
		tick(1);
		chk(dirq, 16'h0001, "done irq");
		pulse_irq_clr;
		chk(dflag, 16'h0000, "flag cleared");
		pulse_rd;
		chk(stat.rx_full, 16'h0000, "rx full after read");
	endtask : t_word16
	task t_byte;
		setup(1'b1, 1'b0, 1'b0);
		irq_en = 1'b0;
		reply = 16'h00B7;
		wr(16'hFF6E);
		wait_flag;
		chk(got, 16'h006E, "byte sent");
		chk(rd_d, 16'h00B7, "byte received");
		tick(2);
		chk(dirq, 16'h0000, "masked irq");
		pulse_irq_clr;
	endtask : t_byte
	task t_ovf;
		int n;
		reply = 16'h0011;
		wr(16'h0022);
		n = 0;
		while (stat.rx_overflow_flag !== 1'b1 && n < 3000) begin
			tick(1);
			n++;
		end
		chk(stat.rx_overflow_flag, 16'h0001, "overflow set");
		chk(rd_d, 16'h00B7, "old word kept");
		tick(1);
		chk(eirq, 16'h0001, "error irq");
		pulse_irq_clr;
		e0 = edges;
		reply = 16'h0044;
		wr(16'h0033);
		tick(100);
		chk(edges - e0, 16'h0000, "edges while overflow");
		chk(stat.rx_overflow_flag, 16'h0001, "overflow holds");
		pulse_rd;
		ovf_clr = 1'b1;
		tick(1);
		ovf_clr = 1'b0;
		wait_flag;
		chk(got, 16'h0033, "held word sent");
		chk(rd_d, 16'h0044, "word after clear");
		pulse_rd;
		pulse_irq_clr;
	endtask : t_ovf
	task t_fill;
		en = 1'b0;
		tick(1);
		wr(16'h0055);
		tick(1);
		wr(16'h0066);
		tick(1);
		chk(wr_rdy, 16'h0000, "buffer full refuses");
		chk(stat.tx_full, 16'h0001, "tx full");
		en = 1'b1;
		wait_flag;
		chk(got, 16'h0055, "first queued word");
		pulse_rd;
		pulse_irq_clr;
		chk(wr_rdy, 16'h0001, "room again");
		wait_flag;
		chk(got, 16'h0066, "second queued word");
		chk(rd_d, 16'h0044, "second reply");
		pulse_rd;
		pulse_irq_clr;
	endtask : t_fill
	task t_roles;
		setup(1'b0, 1'b0, 1'b0);
		chk(sck_oe_b, 16'h0001, "slave takes clock");
		chk(sdo_oe_b, 16'h0001, "deselected slave releases data");
		setup(1'b1, 1'b1, 1'b1);
		tick(2);
		chk(sck, 16'h0001, "idle level high");
	endtask : t_roles

	// ==========================================================
	// Main sequence and verdict
	task print_verdict;
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : print_verdict
	initial begin
		{en, ovf_clr, irq_en, irq_clr, wr_v, rd, sck_in, cpol, w16} = '0;
		sel_b = 1'b1;
		wr_d = '0;
		reply = '0;
		ctrl = '0;
		err_total = 0;
		checks_done = 0;
		cycles = 0;
		i_rst_b = 1'b0;
		repeat (12) @(posedge i_clk);
		#1;
		i_rst_b = 1'b1;
		tick(1);
		t_reset;
		t_word16;
		t_byte;
		t_ovf;
		t_fill;
		t_roles;
		print_verdict;
	end
endmodule : sync_serial_shift_port_tb
